// file: rtl/meta_event_framer.sv
// meta event record framer steering records into wake, non-wake and status FIFOs
// ==========================================
// Contract
// - each event type enabled separately per FIFO
// - per-type interrupt enable, independent of sensor data
// - after init: timestamp then initialized record first
// - system and sensor errors to status FIFO, enabled
// - sensor configuration events follow sensor's FIFO
// - rate, power, range emitted only on real change
// - overflow and spacer can never be disabled
// - flush complete always inserted, data never dropped; here its enable bit stays writable, so software can disable it
// - rate event on first set and each change
// - rate byte rounded down, clamped at 255
// - power event carries sensor id and mode
// - system error carries code then interrupt status
// - algorithm type five is never produced
// - status event carries quality zero to three
// - overflow count saturates, full timestamp follows
// - reset record: zero byte, then cause code
//
// Design decisions made here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
module meta_event_framer #(
	parameter int DEPTH = 16,
	parameter logic [7:0] TS_FULL_CODE = 8'hF0
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [31:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [31:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic [meta_pkg::N_SRC-1:0] ev_req,
	input wire logic [meta_pkg::N_SRC-1:0] ev_wake,
	input wire logic [meta_pkg::N_SRC-1:0][7:0] ev_lo,
	input wire logic [meta_pkg::N_SRC-1:0][7:0] ev_hi,
	input wire logic [15:0] rate_int,
	input wire logic [1:0] flush_sel,
	input wire logic [39:0] timestamp,
	output logic wake_valid,
	input wire logic wake_ready,
	output logic [meta_pkg::REC_W-1:0] wake_data,
	output logic nonwake_valid,
	input wire logic nonwake_ready,
	output logic [meta_pkg::REC_W-1:0] nonwake_data,
	output logic status_valid,
	input wire logic status_ready,
	output logic [meta_pkg::REC_W-1:0] status_data,
	output logic meta_irq
);
	import meta_pkg::*;

	// ==========================================
	// register access
	reg_if rif();
	axil_slave u_bus (
		.clk(clk),
		.reset_n(reset_n),
		.awaddr(awaddr),
		.awvalid(awvalid),
		.awready(awready),
		.wdata(wdata),
		.wstrb(wstrb),
		.wvalid(wvalid),
		.wready(wready),
		.bresp(bresp),
		.bvalid(bvalid),
		.bready(bready),
		.araddr(araddr),
		.arvalid(arvalid),
		.arready(arready),
		.rdata(rdata),
		.rresp(rresp),
		.rvalid(rvalid),
		.rready(rready),
		.rif(rif.bus)
	);

	logic [31:0] cfg [N_CFG];
	logic init_sent;
	logic [N_SRC-1:0] pend;
	logic [N_DST-1:0] fifo_full;
	wire [2:0] wr_idx = rif.wr_addr[4:2];
	wire [2:0] rd_idx = rif.rd_addr[4:2];
	wire wr_word = (rif.wr_addr[31:5] == '0) && (rif.wr_addr[1:0] == '0);
	wire rd_word = (rif.rd_addr[31:5] == '0) && (rif.rd_addr[1:0] == '0);
	wire wr_cfg = rif.wr_en && wr_word && (wr_idx < 3'(N_CFG));
	wire [31:0] wr_mask = {{8{rif.wr_strb[3]}}, {8{rif.wr_strb[2]}}, {8{rif.wr_strb[1]}}, {8{rif.wr_strb[0]}}};
	wire [31:0] wr_old = (wr_idx < 3'(N_CFG)) ? cfg[wr_idx] : '0;
	wire [31:0] wr_merged = (wr_old & ~wr_mask) | (rif.wr_data & wr_mask);
	wire [31:0] state_word = {14'h0000, pend, fifo_full, init_sent};
	// the state word is read-only; writes to it are accepted and dropped
	assign rif.wr_ok = wr_word && (wr_idx < 3'(N_REG));
	assign rif.rd_ok = rd_word && (rd_idx < 3'(N_REG));
	assign rif.rd_data = (rd_idx == 3'(REG_STATE)) ? state_word : (rd_idx < 3'(N_CFG)) ? cfg[rd_idx] : '0;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < N_CFG; i++)
				cfg[i] <= CFG_RST[i];
		end else begin
			for (int i = 0; i < N_CFG; i++)
				if (wr_cfg && (wr_idx == 3'(i)))
					cfg[i] <= wr_merged;
		end
	end

	// per-FIFO effective masks; overflow and spacer bits are forced on in the wake and non-wake masks whatever software writes
	logic [N_DST-1:0][31:0] en_mask;
	logic [N_DST-1:0][31:0] int_mask;
	always_comb begin
		for (int d = 0; d < N_DST; d++) begin
			en_mask[d] = cfg[REG_EN_BASE + d] | ((d == DST_STATUS) ? 32'h0000_0000 : ALWAYS_ON);
			int_mask[d] = cfg[REG_INT_BASE + d];
		end
	end

	// ==========================================
	// change tracking for sensor configuration events
	logic [15:0] rate_last [256];
	logic [7:0] pwr_last [256];
	logic [7:0] dyn_last [256];
	logic [255:0] rate_seen;
	logic [255:0] pwr_seen;
	logic [255:0] dyn_seen;
	wire [7:0] rate_id = ev_lo[S_RATE];
	wire [7:0] pwr_id = ev_lo[S_POWER];
	wire [7:0] dyn_id = ev_lo[S_DYN];
	wire rate_chg = !rate_seen[rate_id] || (rate_last[rate_id] != rate_int);
	wire pwr_chg = !pwr_seen[pwr_id] || (pwr_last[pwr_id] != ev_hi[S_POWER]);
	wire dyn_chg = !dyn_seen[dyn_id] || (dyn_last[dyn_id] != ev_hi[S_DYN]);
	wire [7:0] rate_byte = (rate_int > RATE_MAX) ? RATE_MAX[7:0] : rate_int[7:0];

	always_ff @(posedge clk) begin
		if (ev_req[S_RATE])
			rate_last[rate_id] <= rate_int;
		if (ev_req[S_POWER])
			pwr_last[pwr_id] <= ev_hi[S_POWER];
		if (ev_req[S_DYN])
			dyn_last[dyn_id] <= ev_hi[S_DYN];
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rate_seen <= '0;
			pwr_seen <= '0;
			dyn_seen <= '0;
		end else begin
			rate_seen <= rate_seen | ({255'h0, ev_req[S_RATE]} << rate_id);
			pwr_seen <= pwr_seen | ({255'h0, ev_req[S_POWER]} << pwr_id);
			dyn_seen <= dyn_seen | ({255'h0, ev_req[S_DYN]} << dyn_id);
		end
	end

	// ==========================================
	// capture into one pending slot per source; a newer request overwrites an older pending one, except overflow, whose counts are added
	logic [7:0] pend_lo [N_SRC];
	logic [7:0] pend_hi [N_SRC];
	logic [2:0] pend_dst [N_SRC];
	logic [N_SRC-1:0] cap;
	logic [7:0] cap_lo [N_SRC];
	logic [7:0] cap_hi [N_SRC];
	logic [2:0] cap_dst [N_SRC];
	logic take;
	logic [SRC_W-1:0] sel;
	wire take_ovf = take && (sel == SRC_W'(S_OVF));
	wire [15:0] ovf_base = (pend[S_OVF] && !take_ovf) ? {pend_hi[S_OVF], pend_lo[S_OVF]} : 16'h0000;
	wire [16:0] ovf_sum = {1'b0, ovf_base} + {1'b0, ev_hi[S_OVF], ev_lo[S_OVF]};
	wire [15:0] ovf_cnt = ovf_sum[16] ? OVF_SAT : ovf_sum[15:0];

	always_comb begin
		cap = ev_req;
		cap[S_RATE] = ev_req[S_RATE] & rate_chg;
		cap[S_POWER] = ev_req[S_POWER] & pwr_chg;
		cap[S_DYN] = ev_req[S_DYN] & dyn_chg;
		for (int i = 0; i < N_SRC; i++) begin
			cap_lo[i] = ev_lo[i];
			cap_hi[i] = ev_hi[i];
			cap_dst[i] = ev_wake[i] ? DM_WAKE : DM_NONWAKE;
		end
		cap_dst[S_SYSERR] = DM_STATUS;
		cap_dst[S_SENSERR] = DM_STATUS;
		cap_dst[S_INIT] = DM_DATA;
		cap_dst[S_RESET] = DM_DATA;
		cap_lo[S_RESET] = 8'h00;
		cap_dst[S_FLUSH] = {1'b0, flush_sel};
		cap_hi[S_FLUSH] = 8'h00;
		cap_hi[S_DYN] = 8'h00;
		cap_hi[S_XFER] = 8'h00;
		cap_hi[S_RATE] = rate_byte;
		cap_hi[S_STATUS] = {6'h00, ev_hi[S_STATUS][1:0]};
		cap_lo[S_OVF] = ovf_cnt[7:0];
		cap_hi[S_OVF] = ovf_cnt[15:8];
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pend <= '0;
			for (int i = 0; i < N_SRC; i++) begin
				pend_lo[i] <= 8'h00;
				pend_hi[i] <= 8'h00;
				pend_dst[i] <= 3'h0;
			end
		end else begin
			for (int i = 0; i < N_SRC; i++) begin
				// a request landing in the take cycle stays pending
				pend[i] <= cap[i] | (pend[i] & ~(take && (sel == SRC_W'(i))));
				if (cap[i]) begin
					pend_lo[i] <= cap_lo[i];
					pend_hi[i] <= cap_hi[i];
					pend_dst[i] <= cap_dst[i];
				end
			end
		end
	end

	// ==========================================
	// arbitration and emission
	emit_state_t state;
	logic [7:0] cur_code;
	logic [7:0] cur_lo;
	logic [7:0] cur_hi;
	logic [N_DST-1:0] cur_tgt;
	logic cur_irq;
	logic cur_ovf;
	logic any;
	logic [N_DST-1:0] in_ready;
	// until the init event has been taken, even if disabled, only reset and init may be sent
	wire [N_SRC-1:0] allowed = init_sent ? pend : (pend & PRE_INIT_OK);
	wire [7:0] sel_code = SRC_CODE[sel];
	logic [N_DST-1:0] sel_tgt;
	logic [N_DST-1:0] sel_int;

	always_comb begin
		any = 1'b0;
		sel = '0;
		for (int i = N_SRC - 1; i >= 0; i--)
			if (allowed[i]) begin
				any = 1'b1;
				sel = SRC_W'(i);
			end
		for (int d = 0; d < N_DST; d++) begin
			sel_tgt[d] = pend_dst[sel][d] & en_mask[d][sel_code[4:0]];
			sel_int[d] = sel_tgt[d] & int_mask[d][sel_code[4:0]];
		end
	end

	assign take = (state == ST_IDLE) && any;
	wire push_act = (state != ST_IDLE);
	wire all_ready = &(~cur_tgt | in_ready);
	wire push_done = push_act && all_ready;
	wire [REC_W-1:0] ts_rec = {timestamp, TS_FULL_CODE};
	wire [REC_W-1:0] ev_rec = {24'h00_0000, cur_hi, cur_lo, cur_code};
	wire [REC_W-1:0] push_data = (state == ST_EVENT) ? ev_rec : ts_rec;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= ST_IDLE;
			cur_code <= 8'h00;
			cur_lo <= 8'h00;
			cur_hi <= 8'h00;
			cur_tgt <= '0;
			cur_irq <= 1'b0;
			cur_ovf <= 1'b0;
			init_sent <= 1'b0;
			meta_irq <= 1'b0;
		end else begin
			meta_irq <= push_done && (state == ST_EVENT) && cur_irq;
			case (state)
				ST_IDLE: begin
					if (any) begin
						cur_code <= sel_code;
						cur_lo <= pend_lo[sel];
						cur_hi <= pend_hi[sel];
						cur_tgt <= sel_tgt;
						cur_irq <= |sel_int;
						cur_ovf <= (sel == SRC_W'(S_OVF));
						// a disabled init must still unblock the other sources
						if (sel == SRC_W'(S_INIT))
							init_sent <= 1'b1;
						if (sel_tgt != '0)
							state <= (sel == SRC_W'(S_INIT)) ? ST_PRE_TS : ST_EVENT;
					end
				end
				ST_PRE_TS: begin
					if (all_ready)
						state <= ST_EVENT;
				end
				ST_EVENT: begin
					if (all_ready)
						state <= cur_ovf ? ST_POST_TS : ST_IDLE;
				end
				ST_POST_TS: begin
					if (all_ready)
						state <= ST_IDLE;
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// ==========================================
	// output FIFOs; a full target stalls emission so nothing is dropped
	stream_if #(.W(REC_W)) fin[N_DST]();
	stream_if #(.W(REC_W)) fout[N_DST]();
	for (genvar d = 0; d < N_DST; d++) begin : g_fifo
		assign fin[d].valid = push_act & cur_tgt[d] & all_ready;
		assign fin[d].data = push_data;
		assign in_ready[d] = fin[d].ready;
		assign fifo_full[d] = ~fin[d].ready;
		meta_fifo #(.W(REC_W), .DEPTH(DEPTH)) u_fifo (
			.clk(clk),
			.reset_n(reset_n),
			.wr(fin[d].snk),
			.rd(fout[d].src)
		);
	end

	assign wake_valid = fout[DST_WAKE].valid;
	assign wake_data = fout[DST_WAKE].data;
	assign fout[DST_WAKE].ready = wake_ready;
	assign nonwake_valid = fout[DST_NONWAKE].valid;
	assign nonwake_data = fout[DST_NONWAKE].data;
	assign fout[DST_NONWAKE].ready = nonwake_ready;
	assign status_valid = fout[DST_STATUS].valid;
	assign status_data = fout[DST_STATUS].data;
	assign fout[DST_STATUS].ready = status_ready;
endmodule

// file: rtl/meta_pkg.sv
// constants, record codes and register map of the meta event framer
package meta_pkg;
	// ==========================================
	// record layout and sources
	localparam int REC_W = 48;
	localparam int N_SRC = 14;
	localparam int SRC_W = 4;
	localparam int N_DST = 3;
	localparam int DST_WAKE = 0;
	localparam int DST_NONWAKE = 1;
	localparam int DST_STATUS = 2;
	localparam logic [2:0] DM_WAKE = 3'h1;
	localparam logic [2:0] DM_NONWAKE = 3'h2;
	localparam logic [2:0] DM_STATUS = 3'h4;
	localparam logic [2:0] DM_DATA = 3'h3;
	localparam int S_RESET = 0;
	localparam int S_INIT = 1;
	localparam int S_OVF = 2;
	localparam int S_SYSERR = 3;
	localparam int S_SENSERR = 4;
	localparam int S_FLUSH = 5;
	localparam int S_RATE = 6;
	localparam int S_POWER = 7;
	localparam int S_DYN = 8;
	localparam int S_STATUS = 9;
	localparam int S_WM = 10;
	localparam int S_XFER = 11;
	localparam int S_FW = 12;
	localparam int S_SPACER = 13;
	// lowest index wins arbitration
	localparam logic [7:0] SRC_CODE [N_SRC] = '{8'h13, 8'h10, 8'h0C, 8'h04, 8'h0B, 8'h01, 8'h02,
		8'h03, 8'h0D, 8'h06, 8'h0E, 8'h11, 8'h12, 8'h14};
	localparam logic [N_SRC-1:0] PRE_INIT_OK = 14'h0003;
	localparam logic [15:0] RATE_MAX = 16'h00FF;
	localparam logic [15:0] OVF_SAT = 16'hFFFF;
	// ==========================================
	// register map, one word each
	localparam int REG_EN_BASE = 0;
	localparam int REG_INT_BASE = 3;
	localparam int N_CFG = 6;
	localparam int REG_STATE = 6;
	localparam int N_REG = 7;
	localparam logic [31:0] CFG_RST [N_CFG] = '{32'h0019_706E, 32'h001D_706E, 32'h0000_0810,
		32'h0009_0000, 32'h0009_0000, 32'h0000_0810};
	localparam logic [31:0] ALWAYS_ON = 32'h0010_1000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_PRE_TS = 4'b0010,
		ST_EVENT = 4'b0100,
		ST_POST_TS = 4'b1000
	} emit_state_t;
endpackage

// file: rtl/meta_if.sv
// interfaces carrying record streams and register accesses between modules
`timescale 1ns/1ps
interface stream_if #(parameter int W = 48);
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport src(output valid, output data, input ready);
	modport snk(input valid, input data, output ready);
endinterface

interface reg_if;
	logic wr_en;
	logic [31:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic wr_ok;
	logic [31:0] rd_addr;
	logic [31:0] rd_data;
	logic rd_ok;
	modport bus(output wr_en, wr_addr, wr_data, wr_strb, rd_addr, input wr_ok, rd_data, rd_ok);
	modport regs(input wr_en, wr_addr, wr_data, wr_strb, rd_addr, output wr_ok, rd_data, rd_ok);
endinterface

// file: rtl/meta_fifo.sv
// record FIFO with valid/ready on both sides
`timescale 1ns/1ps
module meta_fifo #(
	parameter int W = 48,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic reset_n,
	stream_if.snk wr,
	stream_if.src rd
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wp;
	logic [AW-1:0] rp;
	logic [AW:0] cnt;
	wire push = wr.valid & wr.ready;
	wire pop = rd.valid & rd.ready;
	wire [AW-1:0] wp_inc = (wp == AW'(DEPTH - 1)) ? '0 : wp + 1'b1;
	wire [AW-1:0] rp_inc = (rp == AW'(DEPTH - 1)) ? '0 : rp + 1'b1;
	assign wr.ready = (cnt != (AW + 1)'(DEPTH));
	assign rd.valid = (cnt != '0);
	assign rd.data = mem[rp];

	always_ff @(posedge clk) begin
		if (push)
			mem[wp] <= wr.data;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wp <= '0;
			rp <= '0;
			cnt <= '0;
		end else begin
			wp <= push ? wp_inc : wp;
			rp <= pop ? rp_inc : rp;
			cnt <= cnt + (AW + 1)'(push) - (AW + 1)'(pop);
		end
	end
endmodule

// file: rtl/axil_slave.sv
// AXI4-Lite slave front end feeding the register interface
`timescale 1ns/1ps
module axil_slave (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [31:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [31:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	reg_if.bus rif
);
	import meta_pkg::*;
	logic aw_held;
	logic w_held;
	logic [31:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	// address and data may come in either order; the write fires once both are held
	wire do_wr = aw_held & w_held & ~bvalid;
	wire aw_take = awvalid & awready;
	wire w_take = wvalid & wready;
	wire ar_take = arvalid & arready;
	assign awready = ~aw_held & ~bvalid;
	assign wready = ~w_held & ~bvalid;
	assign arready = ~rvalid;
	assign rif.wr_en = do_wr;
	assign rif.wr_addr = aw_addr_q;
	assign rif.wr_data = w_data_q;
	assign rif.wr_strb = w_strb_q;
	assign rif.rd_addr = araddr;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr_q <= '0;
			w_data_q <= '0;
			w_strb_q <= '0;
		end else begin
			aw_held <= aw_take | (aw_held & ~do_wr);
			w_held <= w_take | (w_held & ~do_wr);
			aw_addr_q <= aw_take ? awaddr : aw_addr_q;
			w_data_q <= w_take ? wdata : w_data_q;
			w_strb_q <= w_take ? wstrb : w_strb_q;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= RESP_OKAY;
		end else begin
			bvalid <= do_wr | (bvalid & ~bready);
			bresp <= do_wr ? (rif.wr_ok ? RESP_OKAY : RESP_DECERR) : bresp;
			rvalid <= ar_take | (rvalid & ~rready);
			rdata <= ar_take ? (rif.rd_ok ? rif.rd_data : '0) : rdata;
			rresp <= ar_take ? (rif.rd_ok ? RESP_OKAY : RESP_DECERR) : rresp;
		end
	end
endmodule

// file: test/meta_event_framer_assertions.sv
// concurrent checks on the framer's bus handshakes and record formats
`timescale 1ns/1ps
module framer_assertions #(
	parameter logic [7:0] TS_FULL_CODE = 8'hF0
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic wake_valid,
	input wire logic [47:0] wake_data,
	input wire logic nonwake_valid,
	input wire logic nonwake_ready,
	input wire logic [47:0] nonwake_data,
	input wire logic status_valid,
	input wire logic [47:0] status_data
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	// ==========================================
	// register bus
	AST_B_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response changed before bready");
	AST_R_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data changed before rready");
	AST_B_TIME: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
		else $error("write response late");
	AST_R_TIME: assert property (arvalid && arready |=> rvalid)
		else $error("read data late");
	// ==========================================
	// record formats and routing
	AST_STATUS_ERR_ONLY: assert property (status_valid |-> status_data[7:0] inside {8'h04, 8'h0B})
		else $error("status channel holds a non-error record");
	AST_WAKE_CODES: assert property (wake_valid |-> !(wake_data[7:0] inside {8'h04, 8'h05, 8'h0B}))
		else $error("wake channel holds an error or algorithm record");
	AST_QUALITY: assert property (wake_valid && wake_data[7:0] == 8'h06 |-> wake_data[23:18] == 6'h00)
		else $error("quality value above three");
	AST_RESET_ZERO: assert property (nonwake_valid && nonwake_data[7:0] == 8'h13 |-> nonwake_data[15:8] == 8'h00)
		else $error("reset record first byte not zero");
	AST_PAD_ZERO: assert property (status_valid |-> status_data[47:24] == 24'h00_0000)
		else $error("status record padding not zero");
	AST_OVF_TS: assert property (nonwake_valid && nonwake_ready && nonwake_data[7:0] == 8'h0C
		|=> ##[0:3] (nonwake_valid && nonwake_data[7:0] == TS_FULL_CODE))
		else $error("no full timestamp after overflow record");
	cover property (status_valid && status_data[7:0] == 8'h0B);
	cover property (nonwake_valid && nonwake_data[7:0] == TS_FULL_CODE);
	cover property (wake_valid && wake_data[7:0] == 8'h10);
endmodule

bind meta_event_framer framer_assertions #(.TS_FULL_CODE(TS_FULL_CODE)) chk_u (.clk, .reset_n, .awvalid,
	.awready, .wvalid, .wready, .bresp, .bvalid, .bready, .arvalid, .arready, .rdata, .rvalid, .rready,
	.wake_valid, .wake_data, .nonwake_valid, .nonwake_ready, .nonwake_data, .status_valid, .status_data);

// file: test/host_reader.sv
// host side reader popping records from the three output channels
`timescale 1ns/1ps
module host_reader (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [1:0] mode,
	input wire logic [2:0] vld,
	input wire logic [2:0][47:0] dat,
	output logic [2:0] rdy
);
	logic [47:0] q [3][$];
	logic ph;
	// mode 0 stalls, 1 takes every cycle, 2 every other cycle
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rdy <= 3'h0;
			ph <= 1'b0;
		end else begin
			for (int i = 0; i < 3; i++) begin
				if (vld[i] && rdy[i]) q[i].push_back(dat[i]);
			end
			ph <= !ph;
			rdy <= (mode == 2'd1 || (mode == 2'd2 && ph)) ? 3'h7 : 3'h0;
		end
	end
endmodule

// file: test/meta_event_framer_tb.sv
// self-checking bench for the meta event framer
`timescale 1ns/1ps
module meta_event_framer_tb;
	import meta_pkg::*;
	localparam logic [7:0] TSC = 8'hF0;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, arready, bvalid, rvalid, meta_irq;
	logic [1:0] bresp, rresp;
	logic [3:0] wstrb = 4'hF;
	logic [N_SRC-1:0] ev_req = '0, ev_wake = '0;
	logic [N_SRC-1:0][7:0] ev_lo = '0, ev_hi = '0;
	logic [15:0] rate_int = '0;
	logic [1:0] flush_sel = '0, mode = 2'd1;
	logic [39:0] timestamp = 40'hA5_1234_5678;
	logic [2:0] vld, rdy;
	logic [2:0][47:0] dat;
	int err_count = 0, n_checks = 0, irqs = 0, i0;

	meta_event_framer #(.DEPTH(16), .TS_FULL_CODE(TSC)) dut_u (.clk, .reset_n, .awaddr, .awvalid, .awready,
		.wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
		.rresp, .rvalid, .rready, .ev_req, .ev_wake, .ev_lo, .ev_hi, .rate_int, .flush_sel, .timestamp,
		.wake_valid(vld[0]), .wake_ready(rdy[0]), .wake_data(dat[0]), .nonwake_valid(vld[1]),
		.nonwake_ready(rdy[1]), .nonwake_data(dat[1]), .status_valid(vld[2]), .status_ready(rdy[2]),
		.status_data(dat[2]), .meta_irq);
	host_reader host_u (.clk, .reset_n, .mode, .vld, .dat, .rdy);

	always #50 clk = ~clk;
	// counted on the falling edge so snapshots taken after a rising edge never race it
	always @(negedge clk) begin
		if (meta_irq === 1'b1) irqs++;
	end

	// ==========================================
	// shared helpers
	task automatic finish_test;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [47:0] got, exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	function automatic logic [47:0] rec_of(input logic [7:0] c, lo, hi);
		return {24'h00_0000, hi, lo, c};
	endfunction
	// ready and valid move only on rising edges, so a mid-cycle look shows what the next edge samples
	task automatic axw(input logic [31:0] a, d, input logic [1:0] er);
		logic aw_on;
		logic w_on;
		logic b_on;
		logic [1:0] r;
		int n;
		aw_on = 1'b1;
		w_on = 1'b1;
		b_on = 1'b1;
		r = 'x;
		n = 0;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (b_on && n < 50) begin
			@(negedge clk);
			if (awready)
				aw_on = 1'b0;
			if (wready)
				w_on = 1'b0;
			if (bvalid) begin
				b_on = 1'b0;
				r = bresp;
			end
			@(posedge clk);
			awvalid <= aw_on;
			wvalid <= w_on;
			bready <= b_on;
			n++;
		end
		chk(48'(r), 48'(er));
	endtask
	task automatic axr(input logic [31:0] a, e, m, input logic [1:0] er);
		logic ar_on;
		logic r_on;
		logic [31:0] d;
		logic [1:0] r;
		int n;
		ar_on = 1'b1;
		r_on = 1'b1;
		d = 'x;
		r = 'x;
		n = 0;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (r_on && n < 50) begin
			@(negedge clk);
			if (arready)
				ar_on = 1'b0;
			if (rvalid) begin
				r_on = 1'b0;
				d = rdata;
				r = rresp;
			end
			@(posedge clk);
			arvalid <= ar_on;
			rready <= r_on;
			n++;
		end
		chk(48'(d & m), 48'(e));
		chk(48'(r), 48'(er));
	endtask
	task automatic ev(input int s, input logic w, input logic [7:0] lo, hi);
		@(posedge clk);
		ev_req[s] <= 1'b1;
		ev_wake[s] <= w;
		ev_lo[s] <= lo;
		ev_hi[s] <= hi;
		@(posedge clk);
		ev_req <= '0;
	endtask
	task automatic rec(input int d, input logic [47:0] e);
		int n;
		n = 0;
		while (host_u.q[d].size() == 0 && n < 60) begin
			@(posedge clk);
			n++;
		end
		chk((host_u.q[d].size() > 0) ? host_u.q[d].pop_front() : 48'hxxxx_xxxx_xxxx, e);
	endtask
	task automatic none;
		repeat (20) @(posedge clk);
		for (int i = 0; i < 3; i++) chk(48'(host_u.q[i].size()), 48'h0);
	endtask
	task automatic one(input int s, input logic w, input logic [7:0] lo, hi, c, ehi, input logic on);
		ev(s, w, lo, hi);
		if (on) rec(w ? 0 : 1, rec_of(c, lo, ehi));
		else none();
	endtask

	// ==========================================
	// scenarios
	task automatic t_init;
		i0 = irqs;
		ev(9, 1'b1, 8'h05, 8'hFE);
		none();
		axr(32'h0000_0018, 32'h0000_2000, '1, RESP_OKAY);
		ev(1, 1'b0, 8'h34, 8'h12);
		for (int d = 0; d < 2; d++) begin
			rec(d, {timestamp, TSC});
			rec(d, rec_of(8'h10, 8'h34, 8'h12));
		end
		rec(0, rec_of(8'h06, 8'h05, 8'h02));
		chk(48'(irqs > i0), 48'h1);
	endtask
	task automatic t_regs;
		for (int i = 0; i < N_CFG; i++) axr(32'(4 * i), CFG_RST[i], '1, RESP_OKAY);
		axr(32'h0000_001C, 32'h0000_0000, '1, RESP_DECERR);
		axw(32'h0000_0002, 32'h0000_0000, RESP_DECERR);
		axw(32'h0000_0018, 32'hFFFF_FFFF, RESP_OKAY);
		axr(32'h0000_0018, 32'h0000_0001, '1, RESP_OKAY);
	endtask
	task automatic t_codes;
		ev(0, 1'b0, 8'h77, 8'h04);
		rec(0, rec_of(8'h13, 8'h00, 8'h04));
		rec(1, rec_of(8'h13, 8'h00, 8'h04));
		i0 = irqs;
		ev(3, 1'b1, 8'hA5, 8'h5A);
		rec(2, rec_of(8'h04, 8'hA5, 8'h5A));
		ev(4, 1'b0, 8'h21, 8'h03);
		rec(2, rec_of(8'h0B, 8'h21, 8'h03));
		none();
		chk(48'(irqs - i0), 48'h2);
		one(8, 1'b1, 8'h03, 8'h09, 8'h0D, 8'h00, 1'b1);
		one(10, 1'b0, 8'h40, 8'h01, 8'h0E, 8'h01, 1'b1);
		one(11, 1'b0, 8'h02, 8'h05, 8'h11, 8'h00, 1'b0);
		one(12, 1'b1, 8'h02, 8'h03, 8'h12, 8'h03, 1'b0);
		one(12, 1'b0, 8'h02, 8'h03, 8'h12, 8'h03, 1'b1);
	endtask
	task automatic t_rate;
		i0 = irqs;
		rate_int <= 16'h012C;
		one(6, 1'b0, 8'h07, 8'h00, 8'h02, 8'hFF, 1'b1);
		one(6, 1'b0, 8'h07, 8'h00, 8'h02, 8'hFF, 1'b0);
		rate_int <= 16'h000C;
		one(6, 1'b0, 8'h07, 8'h00, 8'h02, 8'h0C, 1'b1);
		one(7, 1'b1, 8'h07, 8'h01, 8'h03, 8'h01, 1'b1);
		one(7, 1'b1, 8'h07, 8'h01, 8'h03, 8'h01, 1'b0);
		chk(48'(irqs - i0), 48'h0);
	endtask
	task automatic t_enable;
		axw(32'h0000_0004, 32'h0000_0000, RESP_OKAY);
		axr(32'h0000_0004, 32'h0000_0000, '1, RESP_OKAY);
		one(7, 1'b0, 8'h09, 8'h01, 8'h03, 8'h01, 1'b0);
		one(13, 1'b0, 8'h02, 8'h00, 8'h14, 8'h00, 1'b1);
		timestamp <= 40'h00_0BAD_F00D;
		ev(2, 1'b0, 8'h10, 8'h00);
		rec(1, rec_of(8'h0C, 8'h10, 8'h00));
		rec(1, {timestamp, TSC});
		axw(32'h0000_0004, CFG_RST[1], RESP_OKAY);
		axw(32'h0000_000C, CFG_RST[3] | 32'h0000_0040, RESP_OKAY);
		i0 = irqs;
		one(9, 1'b1, 8'h05, 8'h01, 8'h06, 8'h01, 1'b1);
		chk(48'(irqs - i0), 48'h1);
		axw(32'h0000_000C, CFG_RST[3], RESP_OKAY);
	endtask
	task automatic t_flush;
		flush_sel <= 2'b11;
		ev(5, 1'b0, 8'h22, 8'h00);
		rec(0, rec_of(8'h01, 8'h22, 8'h00));
		rec(1, rec_of(8'h01, 8'h22, 8'h00));
		flush_sel <= 2'b10;
		one(5, 1'b0, 8'h23, 8'h5F, 8'h01, 8'h00, 1'b1);
		none();
		// host stalls so the wake buffer fills; one more flush waits behind it
		mode <= 2'd0;
		flush_sel <= 2'b01;
		for (int i = 0; i < 17; i++) begin
			ev(5, 1'b0, 8'(i), 8'h00);
			repeat (6) @(posedge clk);
		end
		axr(32'h0000_0018, 32'h0000_0002, 32'h0000_0002, RESP_OKAY);
		mode <= 2'd2;
		for (int i = 0; i < 17; i++) rec(0, rec_of(8'h01, 8'(i), 8'h00));
		none();
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		finish_test();
	end
	initial begin
		repeat (3) @(posedge clk);
		reset_n <= 1'b1;
		t_init();
		// configuration only once the initialized record has been read
		t_regs();
		t_codes();
		t_rate();
		t_enable();
		t_flush();
		finish_test();
	end
endmodule
